/* File: rtl/codec_verb_params.svh */
`ifndef CODEC_VERB_PARAMS_SVH
`define CODEC_VERB_PARAMS_SVH
// ----------------------------------------
// ----------------------------------------
`define VB_GETPAR 12'hF00
`define VB_GETSEL 12'hF01
`define VB_SETSEL 12'h701
`define PID_PIN 8'h0C
`define PID_AMPIN 8'h0D
`define PID_CLEN 8'h0E
`define PID_PWR 8'h0F
`define PID_PROC 8'h10
`define PID_GPIO 8'h11
`define PID_AMPOUT 8'h12
`define PID_KNOB 8'h13
`define N_AFG 8'h01
`define N_CONV0 8'h02
`define N_CONVX 8'h06
`define N_ADCMIC 8'h07
`define N_ADCLIN 8'h08
`define N_ADCMIX 8'h09
`define N_MIXER 8'h0B
`define N_SUM0 8'h0C
`define N_SUM1 8'h0F
`define N_PSEL0 8'h10
`define N_PSEL1 8'h11
`define N_PSEL2 8'h12
`define N_PSEL3 8'h13
`define N_PIN0 8'h14
`define N_PINO1 8'h17
`define N_PINL1 8'h1B
`define N_BEEP 8'h1D
`define N_KNOB 8'h21
`define SEL_COUNT 7
`define RST_MIC 8'h00
`define RST_LIN 8'h02
`define RST_MIX 8'h04
`define RST_PSEL 8'h00
`define AMP_STEP 7'h03
`define AMP_RST 32'h8000_1F17
`define AMPCONV_RST 32'h0000_0000
`define OVR_RST 8'h00
`define CL_SHORT 1'b0
`define CL_ADC 7'h07
`define CL_MIX 7'h0A
`define CL_MIXER 7'h08
`define CL_SUM 7'h02
`define CL_SEL 7'h04
`define CL_PIN 7'h01
`define PWR_SUP 4'hF
`define PROC_COEF 8'h00
`define PROC_BENIGN 1'b1
`define GPIO_WAKE_CAPABLE 1'b0
`define GPIO_UNSOL_CAPABLE 1'b1
`define GPIO_IN_ONLY 8'h00
`define GPIO_OUT_ONLY 8'h00
`define GPIO_BIDIR 8'h02
`define KNOB_DELTA 1'b1
`define KNOB_STEPS 7'h3F
`define PCAP_OUT 5'h1C
`define PCAP_IN 5'h04
`define PCAP_BEEP 5'h00
`define R_CTRL 8'h00
`define R_AMPDEF 8'h04
`define R_AMPCONV 8'h08
`define R_OVR 8'h0C
`define R_LCMD 8'h10
`define R_LRSP 8'h14
`define R_SELA 8'h18
`define R_SELB 8'h1C
`define CTRL_ADDR_RST 4'h0
`define CTRL_EN_RST 1'b1
`define LINK_BITS 6'h20
`endif

/* File: rtl/codec_verb_pkg.sv */
package codec_verb_pkg;
	typedef struct packed {
		logic [3:0]  codecLinkAddress;
		logic [7:0]  nodeIdentifier;
		logic [11:0] verbId;
		logic [7:0]  payload;
	} cmd_word_s;
	typedef struct packed {
		logic       mute;
		logic [7:0] rsvdA;
		logic [6:0] stepSize;
		logic       rsvdB;
		logic [6:0] knob_step_count;
		logic       rsvdC;
		logic [6:0] offset;
	} amp_caps_s;
	typedef logic [7:0] sel_idx_t;
endpackage : codec_verb_pkg

/* File: rtl/verb_link_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface verb_link_if
	import codec_verb_pkg::*;
();
	logic        cmdValid;
	cmd_word_s   cmdWord;
	logic        rspValid;
	logic [31:0] rspWord;
	modport core (input cmdValid, input cmdWord, output rspValid, output rspWord);
	modport link (output cmdValid, output cmdWord, input rspValid, input rspWord);
endinterface : verb_link_if
`default_nettype wire

/* File: rtl/conn_sel_reg.sv */
`timescale 1ns/10ps
`default_nettype none
module conn_sel_reg
	import codec_verb_pkg::*;
#(
	parameter sel_idx_t RESET_IDX = 8'h00
)
(
	// clock and control
	input  wire logic     core_clk,
	input  wire logic     rst,
	input  wire logic     ce,
	// update
	input  wire logic     wrEn,
	input  wire sel_idx_t wrIdx,
	// selection
	output var sel_idx_t  idx_q
);
	always_ff @(posedge core_clk)
	begin
		if (rst)
			idx_q <= RESET_IDX;
		else if (ce && wrEn)
			idx_q <= wrIdx;
	end
endmodule : conn_sel_reg
`default_nettype wire

/* File: rtl/verb_link_serdes.sv */
`timescale 1ns/10ps
`default_nettype none
`include "codec_verb_params.svh"
module verb_link_serdes
	import codec_verb_pkg::*;
(
	// clock and control
	input  wire logic core_clk,
	input  wire logic rst,
	input  wire logic ce,
	// link pins
	input  wire logic linkBitClk,
	input  wire logic linkSync,
	input  wire logic linkCmdData,
	output logic      linkRspData,
	output logic      linkRspOe,
	// verb side
	verb_link_if.link lnk
);
	logic [2:0]  meta_q;
	logic [2:0]  pin_q;
	logic        clkPrev_q;
	logic        rxBusy_q;
	logic [5:0]  rxCnt_q;
	logic [31:0] rxShift_q;
	logic [5:0]  txCnt_q;
	logic [31:0] txShift_q;
	logic        cmdValid_q;
	cmd_word_s   cmdWord_q;
	logic        rise;
	logic        fall;

	assign rise = pin_q[0] & ~clkPrev_q;
	assign fall = ~pin_q[0] & clkPrev_q;
	assign lnk.cmdValid = cmdValid_q;
	assign lnk.cmdWord = cmdWord_q;

	// meta stage feeds only the second stage
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			meta_q <= 3'h0;
			pin_q <= 3'h0;
			clkPrev_q <= 1'b0;
		end
		else if (ce)
		begin
			meta_q <= {linkCmdData, linkSync, linkBitClk};
			pin_q <= meta_q;
			clkPrev_q <= pin_q[0];
		end
	end

	// command bits taken msb first on bit clock rises after sync
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rxBusy_q <= 1'b0;
			rxCnt_q <= 6'h00;
			rxShift_q <= 32'h0000_0000;
			cmdValid_q <= 1'b0;
			cmdWord_q <= '0;
		end
		else if (ce)
		begin
			cmdValid_q <= 1'b0;
			if (rise && !rxBusy_q && pin_q[1])
			begin
				rxBusy_q <= 1'b1;
				rxCnt_q <= 6'h00;
			end
			else if (rise && rxBusy_q)
			begin
				rxShift_q <= {rxShift_q[30:0], pin_q[2]};
				rxCnt_q <= rxCnt_q + 6'h01;
				if (rxCnt_q == `LINK_BITS - 6'h01)
				begin
					rxBusy_q <= 1'b0;
					cmdValid_q <= 1'b1;
					cmdWord_q <= {rxShift_q[30:0], pin_q[2]};
				end
			end
		end
	end

	// response driven on falls; a new response restarts the shift
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			txCnt_q <= 6'h00;
			txShift_q <= 32'h0000_0000;
			linkRspData <= 1'b0;
			linkRspOe <= 1'b0;
		end
		else if (ce)
		begin
			if (lnk.rspValid)
			begin
				txCnt_q <= `LINK_BITS;
				txShift_q <= lnk.rspWord;
			end
			else if (fall && txCnt_q != 6'h00)
			begin
				linkRspData <= txShift_q[31];
				linkRspOe <= 1'b1;
				txShift_q <= {txShift_q[30:0], 1'b0};
				txCnt_q <= txCnt_q - 6'h01;
			end
			else if (fall)
			begin
				linkRspOe <= 1'b0;
				linkRspData <= 1'b0;
			end
		end
	end
endmodule : verb_link_serdes
`default_nettype wire

/* File: rtl/codec_verb_responder.sv */
`timescale 1ns/10ps
`default_nettype none
`include "codec_verb_params.svh"
module codec_verb_responder
	import codec_verb_pkg::*;
(
	// clock and control
	input  wire logic        core_clk,
	input  wire logic        rst,
	input  wire logic        ce,
	// wishbone register slave
	input  wire logic        wbCyc,
	input  wire logic        wbStb,
	input  wire logic        wbWe,
	input  wire logic [7:0]  wbAdr,
	input  wire logic [3:0]  wbSel,
	input  wire logic [31:0] wbDatWr,
	output logic [31:0]      wbDatRd,
	output logic             wbAck,
	// audio link
	input  wire logic        linkBitClk,
	input  wire logic        linkSync,
	input  wire logic        linkCmdData,
	output logic             linkRspData,
	output logic             linkRspOe
);
	localparam sel_idx_t SEL_NODE [0:`SEL_COUNT-1] = '{`N_ADCMIC, `N_ADCLIN,
		`N_ADCMIX, `N_PSEL0, `N_PSEL1, `N_PSEL2, `N_PSEL3};
	localparam sel_idx_t SEL_RST [0:`SEL_COUNT-1] = '{`RST_MIC, `RST_LIN,
		`RST_MIX, `RST_PSEL, `RST_PSEL, `RST_PSEL, `RST_PSEL};

	logic [3:0]          ctrlAddr_q;
	logic                ctrlEn_q;
	amp_caps_s           ampDef_q;
	amp_caps_s           ampConv_q;
	logic [7:0]          ovr_q;
	logic [31:0]         lastCmd_q;
	logic [31:0]         lastRsp_q;
	logic [31:0]         datRd_q;
	logic                ack_q;
	logic                rspValid_q;
	logic [31:0]         rspWord_q;
	logic [31:0]         rspWord_d;
	logic [31:0]         readMux;
	logic [7:0]          regAdr;
	logic                wbReq;
	logic                wbWrite;
	sel_idx_t            selIdx [0:`SEL_COUNT-1];
	logic [`SEL_COUNT-1:0] selWr;
	logic                selHit;
	cmd_word_s           cmd;
	logic [7:0]          node_identifier;
	logic [7:0]          convOff;
	logic                addressed;
	logic                isAfg;
	logic                isPin;
	logic                isConv;
	logic                ovrHit;
	amp_caps_s           amp;
	logic [4:0]          pinCaps;
	logic [6:0]          clen;

	verb_link_if lnk ();

	verb_link_serdes u_serdes (
		.core_clk    (core_clk),
		.rst         (rst),
		.ce          (ce),
		.linkBitClk  (linkBitClk),
		.linkSync    (linkSync),
		.linkCmdData (linkCmdData),
		.linkRspData (linkRspData),
		.linkRspOe   (linkRspOe),
		.lnk         (lnk.link)
	);

	for (genvar i = 0; i < `SEL_COUNT; i++)
	begin : g_sel
		conn_sel_reg #(
			.RESET_IDX (SEL_RST[i])
		) u_sel (
			.core_clk (core_clk),
			.rst      (rst),
			.ce       (ce),
			.wrEn     (selWr[i]),
			.wrIdx    (cmd.payload),
			.idx_q    (selIdx[i])
		);
	end

	// ----------------------------------------
	// verb decode
	// ----------------------------------------
	function automatic logic [31:0] ampWord(input amp_caps_s a);
		return {a.mute, 8'h00, `AMP_STEP, 1'b0, a.knob_step_count, 1'b0, a.offset};
	endfunction : ampWord

	assign cmd = lnk.cmdWord;
	assign node_identifier = cmd.nodeIdentifier;
	// other codec addresses share the link, stay silent for them
	assign addressed = lnk.cmdValid && ctrlEn_q && cmd.codecLinkAddress == ctrlAddr_q;
	assign isAfg = node_identifier == `N_AFG;
	assign isPin = node_identifier >= `N_PIN0 && node_identifier <= `N_BEEP;
	assign isConv = node_identifier >= `N_CONV0 && node_identifier <= `N_ADCMIX && node_identifier != `N_CONVX;
	assign convOff = node_identifier - `N_CONV0;
	assign ovrHit = isConv && ovr_q[convOff[2:0]];
	assign amp = isAfg ? ampDef_q : ampConv_q;
	assign pinCaps = node_identifier <= `N_PINO1 ? `PCAP_OUT : (node_identifier == `N_BEEP ? `PCAP_BEEP : `PCAP_IN);

	always_comb
	begin
		clen = 7'h00;
		if (node_identifier == `N_ADCMIC || node_identifier == `N_ADCLIN)
			clen = `CL_ADC;
		else if (node_identifier == `N_ADCMIX)
			clen = `CL_MIX;
		else if (node_identifier == `N_MIXER)
			clen = `CL_MIXER;
		else if (node_identifier >= `N_SUM0 && node_identifier <= `N_SUM1)
			clen = `CL_SUM;
		else if (node_identifier >= `N_PSEL0 && node_identifier <= `N_PSEL3)
			clen = `CL_SEL;
		else if (node_identifier >= `N_PIN0 && node_identifier <= `N_PINL1)
			clen = `CL_PIN;
	end

	always_comb
	begin
		rspWord_d = 32'h0000_0000;
		selWr = '0;
		selHit = 1'b0;
		for (int i = 0; i < `SEL_COUNT; i++)
			if (node_identifier == SEL_NODE[i])
				selHit = 1'b1;
		case (cmd.verbId)
			`VB_GETPAR:
			begin
				case (cmd.payload)
					`PID_PIN:
						if (isPin)
							rspWord_d = {27'h0000000, pinCaps};
					`PID_AMPIN,
					`PID_AMPOUT:
						if (isAfg || ovrHit)
							rspWord_d = ampWord(amp);
					`PID_CLEN:
						rspWord_d = {24'h000000, `CL_SHORT, clen};
					`PID_PWR:
						if (isAfg)
							rspWord_d = {28'h0000000, `PWR_SUP};
					`PID_PROC:
						if (isAfg)
							rspWord_d = {16'h0000, `PROC_COEF, 7'h00, `PROC_BENIGN};
					`PID_GPIO:
						if (isAfg)
							rspWord_d = {`GPIO_WAKE_CAPABLE, `GPIO_UNSOL_CAPABLE, 6'h00,
								`GPIO_IN_ONLY, `GPIO_OUT_ONLY, `GPIO_BIDIR};
					`PID_KNOB:
						if (node_identifier == `N_KNOB)
							rspWord_d = {24'h000000, `KNOB_DELTA, `KNOB_STEPS};
					default:
						rspWord_d = 32'h0000_0000;
				endcase
			end
			`VB_GETSEL:
			begin
				for (int i = 0; i < `SEL_COUNT; i++)
					if (node_identifier == SEL_NODE[i])
						rspWord_d = {24'h000000, selIdx[i]};
			end
			`VB_SETSEL:
			begin
				for (int i = 0; i < `SEL_COUNT; i++)
					selWr[i] = addressed && node_identifier == SEL_NODE[i];
			end
			default:
				rspWord_d = 32'h0000_0000;
		endcase
	end

	// one cycle from command to response
	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			rspValid_q <= 1'b0;
			rspWord_q <= 32'h0000_0000;
			lastCmd_q <= 32'h0000_0000;
			lastRsp_q <= 32'h0000_0000;
		end
		else if (ce)
		begin
			rspValid_q <= addressed;
			if (addressed)
			begin
				rspWord_q <= rspWord_d;
				lastCmd_q <= cmd;
				lastRsp_q <= rspWord_d;
			end
		end
	end

	assign lnk.rspValid = rspValid_q;
	assign lnk.rspWord = rspWord_q;

	// ----------------------------------------
	// wishbone slave
	// ----------------------------------------
	function automatic logic [31:0] mergeBytes(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] be);
		logic [31:0] res;
		res = old;
		for (int b = 0; b < 4; b++)
			if (be[b])
				res[b*8 +: 8] = nw[b*8 +: 8];
		return res;
	endfunction : mergeBytes

	assign wbReq = wbCyc && wbStb;
	assign wbWrite = wbReq && wbWe && ack_q;
	assign regAdr = {wbAdr[7:2], 2'b00};
	assign wbAck = ack_q;
	assign wbDatRd = datRd_q;

	always_ff @(posedge core_clk)
	begin
		if (rst)
			ack_q <= 1'b0;
		else if (ce)
			ack_q <= wbReq && !ack_q;
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
		begin
			ctrlAddr_q <= `CTRL_ADDR_RST;
			ctrlEn_q <= `CTRL_EN_RST;
			ampDef_q <= `AMP_RST;
			ampConv_q <= `AMPCONV_RST;
			ovr_q <= `OVR_RST;
		end
		else if (ce && wbWrite)
		begin
			if (regAdr == `R_CTRL && wbSel[0])
				ctrlAddr_q <= wbDatWr[3:0];
			if (regAdr == `R_CTRL && wbSel[1])
				ctrlEn_q <= wbDatWr[8];
			if (regAdr == `R_AMPDEF)
				ampDef_q <= mergeBytes(ampDef_q, wbDatWr, wbSel);
			if (regAdr == `R_AMPCONV)
				ampConv_q <= mergeBytes(ampConv_q, wbDatWr, wbSel);
			if (regAdr == `R_OVR && wbSel[0])
				ovr_q <= wbDatWr[7:0];
		end
	end

	always_comb
	begin
		case (regAdr)
			`R_CTRL:    readMux = {23'h000000, ctrlEn_q, 4'h0, ctrlAddr_q};
			`R_AMPDEF:  readMux = ampWord(ampDef_q);
			`R_AMPCONV: readMux = ampWord(ampConv_q);
			`R_OVR:     readMux = {24'h000000, ovr_q};
			`R_LCMD:    readMux = lastCmd_q;
			`R_LRSP:    readMux = lastRsp_q;
			`R_SELA:    readMux = {8'h00, selIdx[2], selIdx[1], selIdx[0]};
			`R_SELB:    readMux = {selIdx[6], selIdx[5], selIdx[4], selIdx[3]};
			default:    readMux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (rst)
			datRd_q <= 32'h0000_0000;
		else if (ce && wbReq && !ack_q)
			datRd_q <= readMux;
	end

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (rst);

	logic getPar;
	logic getSel;
	logic setSel;
	assign getPar = addressed && ce && cmd.verbId == `VB_GETPAR;
	assign getSel = addressed && ce && cmd.verbId == `VB_GETSEL;
	assign setSel = addressed && ce && cmd.verbId == `VB_SETSEL;

	a_pin_caps_out: assert property (getPar && cmd.payload == `PID_PIN && node_identifier == `N_PIN0
		|=> rspWord_q == {27'h0000000, `PCAP_OUT})
		else $error("pin caps wrong on output pin");
	a_pin_caps_only: assert property (getPar && cmd.payload == `PID_PIN && !isPin
		|=> rspWord_q == 32'h0000_0000)
		else $error("pin caps on non pin node");
	a_amp_in_layout: assert property (getPar && cmd.payload == `PID_AMPIN && isAfg
		|=> rspWord_q[22:16] == `AMP_STEP && rspWord_q[30:23] == 8'h00
		&& rspWord_q[31] == $past(ampDef_q.mute))
		else $error("input amp caps layout wrong");
	a_amp_out_steps: assert property (getPar && cmd.payload == `PID_AMPOUT && isAfg
		|=> rspWord_q[14:8] == $past(ampDef_q.knob_step_count)
		&& rspWord_q[6:0] == $past(ampDef_q.offset))
		else $error("output amp caps fields wrong");
	a_amp_override: assert property (getPar && cmd.payload == `PID_AMPIN && isConv
		|=> rspWord_q == ($past(ovrHit) ? ampWord($past(ampConv_q)) : 32'h0000_0000))
		else $error("converter amp override wrong");
	a_conn_len: assert property (getPar && cmd.payload == `PID_CLEN
		|=> rspWord_q[31:7] == 25'h0000000 && rspWord_q[6:0] == $past(clen))
		else $error("connection list length format wrong");
	a_pin_fixed_in: assert property (getPar && cmd.payload == `PID_CLEN && node_identifier == `N_PINL1
		|=> rspWord_q == {25'h0000000, `CL_PIN})
		else $error("pin list length not one");
	a_power_states: assert property (getPar && cmd.payload == `PID_PWR && isAfg
		|=> rspWord_q == {28'h0000000, `PWR_SUP})
		else $error("power states wrong");
	a_proc_caps: assert property (getPar && cmd.payload == `PID_PROC && isAfg
		|=> rspWord_q[31:16] == 16'h0000 && rspWord_q[7:1] == 7'h00)
		else $error("processing caps reserved bits set");
	a_gpio_caps: assert property (getPar && cmd.payload == `PID_GPIO && isAfg
		|=> rspWord_q[31:30] == 2'h1 && rspWord_q[23:0] == {16'h0000, `GPIO_BIDIR})
		else $error("gpio caps wrong");
	a_knob_caps: assert property (getPar && cmd.payload == `PID_KNOB && node_identifier == `N_KNOB
		|=> rspWord_q == {24'h000000, `KNOB_DELTA, `KNOB_STEPS})
		else $error("knob caps wrong");
	a_get_sel_mix: assert property (getSel && node_identifier == `N_ADCMIX
		|=> rspValid_q && rspWord_q == {24'h000000, $past(selIdx[2])})
		else $error("get select index wrong");
	a_sel_reset: assert property ($fell(rst) |-> selIdx[0] == `RST_MIC
		&& selIdx[1] == `RST_LIN && selIdx[2] == `RST_MIX && selIdx[3] == `RST_PSEL
		&& selIdx[6] == `RST_PSEL)
		else $error("selector reset index wrong");
	a_get_sel_none: assert property (getSel && !selHit
		|=> rspWord_q == 32'h0000_0000)
		else $error("get select on plain node not zero");
	a_set_sel_zero: assert property (setSel |=> rspWord_q == 32'h0000_0000)
		else $error("set select response not zero");
	a_sel_readback: assert property (setSel && node_identifier == `N_PSEL3
		|=> selIdx[6] == $past(cmd.payload) ##1 ce ##0 $stable(selIdx[6]) || $past(setSel))
		else $error("written index not held");
	a_unknown_param: assert property (getPar && cmd.payload > `PID_KNOB
		|=> rspWord_q == 32'h0000_0000)
		else $error("unsupported parameter not zero");

	c_set_then_get: cover property (getSel && node_identifier == `N_PSEL3 && selIdx[6] != `RST_PSEL);
	c_amp_override: cover property (getPar && cmd.payload == `PID_AMPIN && ovrHit);
	c_pin_sel_get: cover property (getSel && node_identifier == `N_PSEL2);
	c_bus_write: cover property (wbWrite && regAdr == `R_OVR);
endmodule : codec_verb_responder
`default_nettype wire

/* File: sim/host_link_model.sv */
`timescale 1ns/10ps
`default_nettype none
module host_link_model
(
	// clock
	input  wire logic core_clk,
	// link pins
	output logic      linkBitClk,
	output logic      linkSync,
	output logic      linkCmdData,
	input  wire logic linkRspData,
	input  wire logic linkRspOe
);
	initial
	begin
		linkBitClk = 1'b0;
		linkSync = 1'b0;
		linkCmdData = 1'b0;
	end

	// half a bit period, 80 ns
	task automatic half();
		repeat (8) @(posedge core_clk);
	endtask : half

	// bit clock runs only inside a frame; released data line parks at the inverse bit
	task automatic frame(input logic [31:0] cmd, output logic [31:0] rsp,
		output logic oeAll, output logic oeAny, output logic oeEnd);
		oeAll = 1'b1;
		oeAny = 1'b0;
		linkSync <= 1'b1;
		half();
		linkBitClk <= 1'b1;
		half();
		for (int i = 31; i >= 0; i--)
		begin
			linkBitClk <= 1'b0;
			linkSync <= 1'b0;
			linkCmdData <= cmd[i];
			half();
			linkBitClk <= 1'b1;
			half();
		end
		linkCmdData <= ~cmd[0];
		for (int k = 31; k >= 0; k--)
		begin
			linkBitClk <= 1'b0;
			half();
			linkBitClk <= 1'b1;
			rsp[k] = linkRspData;
			oeAll = oeAll & linkRspOe;
			oeAny = oeAny | linkRspOe;
			half();
		end
		linkBitClk <= 1'b0;
		half();
		oeEnd = linkRspOe;
	endtask : frame
endmodule : host_link_model
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "codec_verb_params.svh"
module tb;
	localparam logic [11:0] GP = `VB_GETPAR;
	localparam logic [11:0] GS = `VB_GETSEL;
	localparam logic [11:0] SS = `VB_SETSEL;
	logic        core_clk;
	logic        rst = 1'b1;
	logic        wbCyc = 1'b0;
	logic        wbStb = 1'b0;
	logic        wbWe = 1'b0;
	logic [7:0]  wbAdr = 8'h00;
	logic [3:0]  wbSel = 4'h0;
	logic [31:0] wbDatWr = 32'h0;
	logic [31:0] wbDatRd;
	logic        wbAck;
	logic        linkBitClk;
	logic        linkSync;
	logic        linkCmdData;
	logic        linkRspData;
	logic        linkRspOe;
	logic [3:0]  hostAddr = 4'h0;
	int          miscompares = 0;
	int          checked = 0;
	int          cycles = 0;

	codec_verb_responder dut (.core_clk(core_clk), .rst(rst), .ce(1'b1), .wbCyc(wbCyc),
		.wbStb(wbStb), .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatWr(wbDatWr),
		.wbDatRd(wbDatRd), .wbAck(wbAck), .linkBitClk(linkBitClk), .linkSync(linkSync),
		.linkCmdData(linkCmdData), .linkRspData(linkRspData), .linkRspOe(linkRspOe));
	host_link_model host (.core_clk(core_clk), .linkBitClk(linkBitClk), .linkSync(linkSync),
		.linkCmdData(linkCmdData), .linkRspData(linkRspData), .linkRspOe(linkRspOe));

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	// ------------------------------
	// checks and bus cycles
	// ------------------------------
	task automatic end_of_test();
		$display("compares %0d, mismatches %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : end_of_test

	// ceiling leaves headroom over roughly 52.5k cycles of traffic
	always @(posedge core_clk)
	begin
		cycles++;
		if (cycles == 80000)
		begin
			miscompares++;
			$display("wrong value at %0t: run timed out", $time);
			end_of_test();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask : chk

	task automatic chkFlag(input logic got, input logic exp, input string what);
		checked++;
		if (got !== exp)
		begin
			miscompares++;
			$display("wrong value at %0t: %s flag got %b", $time, what, got);
		end
	endtask : chkFlag

	task automatic doReset();
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (8) @(posedge core_clk);
		rst <= 1'b0;
	endtask : doReset

	task automatic wbXfer(input logic we, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] q);
		@(posedge core_clk);
		wbCyc <= 1'b1;
		wbStb <= 1'b1;
		wbWe <= we;
		wbAdr <= a;
		wbSel <= s;
		wbDatWr <= d;
		do
		begin
			@(posedge core_clk);
		end
		while (wbAck !== 1'b1);
		q = wbDatRd;
		wbCyc <= 1'b0;
		wbStb <= 1'b0;
		chkFlag(wbAck, 1'b1, "bus ack");
	endtask : wbXfer

	task automatic regWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] q;
		wbXfer(1'b1, a, d, s, q);
	endtask : regWrite

	task automatic regCheck(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] q;
		wbXfer(1'b0, a, 32'h0, 4'hF, q);
		chk(q, exp, "register read");
	endtask : regCheck

	task automatic ask(input logic [7:0] nd, input logic [11:0] vb, input logic [7:0] pl,
		input logic [31:0] exp);
		logic [31:0] rsp;
		logic        oeAll;
		logic        oeAny;
		logic        oeEnd;
		host.frame({hostAddr, nd, vb, pl}, rsp, oeAll, oeAny, oeEnd);
		chk(rsp, exp, "response word");
		chkFlag(oeAll, 1'b1, "driving");
		chkFlag(oeEnd, 1'b0, "released");
	endtask : ask

	task automatic silent(input logic [7:0] nd);
		logic [31:0] rsp;
		logic        oeAll;
		logic        oeAny;
		logic        oeEnd;
		host.frame({hostAddr, nd, GS, 8'h00}, rsp, oeAll, oeAny, oeEnd);
		chkFlag(oeAny, 1'b0, "foreign address");
	endtask : silent

	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_defaults();
		ask(8'h07, GS, 8'h00, 32'h0000_0000);
		ask(8'h08, GS, 8'h00, 32'h0000_0002);
		ask(8'h09, GS, 8'h00, 32'h0000_0004);
		for (int n = 16; n <= 19; n++)
			ask(8'(n), GS, 8'h00, 32'h0000_0000);
		regCheck(8'h18, 32'h0004_0200);
		regCheck(8'h1C, 32'h0000_0000);
		$display("test defaults done");
	endtask : t_defaults

	task automatic t_regs();
		regCheck(8'h00, 32'h0000_0100);
		regCheck(8'h04, 32'h8003_1F17);
		regCheck(8'h08, 32'h0003_0000);
		regCheck(8'h0C, 32'h0000_0000);
		regCheck(8'h10, 32'h013F_0100);
		regWrite(8'h18, 32'hFFFF_FFFF, 4'hF);
		regCheck(8'h18, 32'h0004_0200);
		regWrite(8'h40, 32'hFFFF_FFFF, 4'hF);
		regCheck(8'h40, 32'h0000_0000);
		$display("test registers done");
	endtask : t_regs

	task automatic t_params();
		ask(8'h14, GP, 8'h0C, 32'h0000_001C);
		ask(8'h18, GP, 8'h0C, 32'h0000_0004);
		ask(8'h1D, GP, 8'h0C, 32'h0000_0000);
		ask(8'h07, GP, 8'h0C, 32'h0000_0000);
		ask(8'h07, GP, 8'h0E, 32'h0000_0007);
		ask(8'h09, GP, 8'h0E, 32'h0000_000A);
		ask(8'h0B, GP, 8'h0E, 32'h0000_0008);
		ask(8'h10, GP, 8'h0E, 32'h0000_0004);
		ask(8'h14, GP, 8'h0E, 32'h0000_0001);
		ask(8'h1B, GP, 8'h0E, 32'h0000_0001);
		ask(8'h01, GP, 8'h0F, 32'h0000_000F);
		ask(8'h01, GP, 8'h10, 32'h0000_0001);
		ask(8'h01, GP, 8'h11, 32'h4000_0002);
		ask(8'h21, GP, 8'h13, 32'h0000_00BF);
		ask(8'h01, GP, 8'h05, 32'h0000_0000);
		ask(8'h01, GP, 8'h20, 32'h0000_0000);
		$display("test parameters done");
	endtask : t_params

	task automatic t_amp();
		ask(8'h01, GP, 8'h0D, 32'h8003_1F17);
		ask(8'h01, GP, 8'h12, 32'h8003_1F17);
		ask(8'h07, GP, 8'h0D, 32'h0000_0000);
		regWrite(8'h04, 32'h8003_0000, 4'hF);
		ask(8'h01, GP, 8'h0D, 32'h8003_0000);
		regWrite(8'h08, 32'h0000_0A05, 4'hF);
		regWrite(8'h0C, 32'h0000_0020, 4'hF);
		ask(8'h07, GP, 8'h0D, 32'h0003_0A05);
		ask(8'h07, GP, 8'h12, 32'h0003_0A05);
		ask(8'h08, GP, 8'h0D, 32'h0000_0000);
		$display("test amplifiers done");
	endtask : t_amp

	task automatic t_select();
		ask(8'h09, SS, 8'h09, 32'h0000_0000);
		ask(8'h07, SS, 8'h06, 32'h0000_0000);
		ask(8'h13, SS, 8'h03, 32'h0000_0000);
		ask(8'h0B, SS, 8'h05, 32'h0000_0000);
		ask(8'h09, GS, 8'h00, 32'h0000_0009);
		ask(8'h13, GS, 8'h00, 32'h0000_0003);
		ask(8'h0B, GS, 8'h00, 32'h0000_0000);
		ask(8'h21, GS, 8'h00, 32'h0000_0000);
		regCheck(8'h18, 32'h0009_0206);
		regCheck(8'h1C, 32'h0300_0000);
		ask(8'h07, SS, 8'h01, 32'h0000_0000);
		ask(8'h07, GS, 8'h00, 32'h0000_0001);
		$display("test selectors done");
	endtask : t_select

	task automatic t_address();
		regWrite(8'h00, 32'h0000_0003, 4'h1);
		regCheck(8'h00, 32'h0000_0103);
		silent(8'h07);
		hostAddr = 4'h3;
		ask(8'h08, GS, 8'h00, 32'h0000_0002);
		regWrite(8'h00, 32'h0000_0003, 4'hF);
		silent(8'h08);
		regWrite(8'h00, 32'h0000_0100, 4'hF);
		hostAddr = 4'h0;
		$display("test addressing done");
	endtask : t_address

	initial
	begin
		doReset();
		t_defaults();
		t_regs();
		t_params();
		t_amp();
		t_select();
		t_address();
		doReset();
		t_defaults();
		end_of_test();
	end
endmodule : tb
`default_nettype wire
